/* hw/irq_status_defs.svh */
`ifndef IRQ_STATUS_DEFS_SVH
`define IRQ_STATUS_DEFS_SVH

// word indices inside one channel window, taken from haddr bits 5:2
`define OFF_MAIN 4'h0
`define OFF_MASK 4'h1
`define OFF_EXT 4'h2
`define OFF_TBCH 4'h3
`define OFF_CFG2 4'h4
`define OFF_RSTAT 4'h5
`define OFF_RCTRL 4'h6
`define OFF_RADDR 4'h7
// haddr bit that selects channel b
`define CH_SEL_BIT 6

// main status fields
`define MAIN_RME 7
`define MAIN_RPF 6
`define MAIN_PCE 5
`define MAIN_SRC_MASK 8'hf8
`define PTR_ICA 2
`define PTR_EXA 1
`define PTR_EXB 0
// extended status fields
`define EXT_RFO 6
`define EXT_RFS 3
// control fields
`define TBCH_DMA 7
`define CFG2_RIE 3
`define CFG2_TRANSP 0
// receive status fields
`define RSTAT_CRC 5
`define RSTAT_ABORT 4

`define RST_BYTE 8'h00
`define MASK_RST 8'h00

`endif

/* hw/irq_status_pkg.sv */
package irq_status_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0]
	{
		FS_IDLE = 2'b00,
		FS_BYTE1 = 2'b01,
		FS_BYTE2 = 2'b10
	} fs_state_e;
endpackage

/* hw/hdlc_irq_status.sv */
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "irq_status_defs.svh"

module hdlc_irq_status
(
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic CE_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic [1:0] FRAME_END_IN,
	input wire logic [1:0] FRAME_IS_I_IN,
	input wire logic [1:0] FRAME_IS_S_IN,
	input wire logic [1:0] CRC_ERR_IN,
	input wire logic [1:0] ABORT_IN,
	input wire logic [1:0] NS_BAD_IN,
	input wire logic [1:0] NR_BAD_IN,
	input wire logic [1:0] HAS_IFIELD_IN,
	input wire logic [1:0] POOL_32_IN,
	input wire logic [1:0] DMA_MSG_DONE_IN,
	input wire logic [1:0] FIFO_FULL_IN,
	input wire logic [1:0] OPEN_FLAG_IN,
	input wire logic [1:0] ADDR_MATCH_IN,
	input wire logic [1:0] RX_BYTE_IN,
	input wire irq_status_pkg::byte_t CTRL_FIELD_IN [2],
	input wire irq_status_pkg::byte_t ADDR_FIELD_IN [2],
	input wire logic [3:0] RX_STAT_IN [2],
	output logic [1:0] SFRAME_REQ_OUT,
	output logic [1:0] SEQ_ADVANCE_OUT,
	output logic [1:0] DMA_MODE_OUT,
	output logic IRQ_N_OUT
);
	import irq_status_pkg::*;

	byte_t main_src [2];
	byte_t ext_src [2];
	byte_t mask [2];
	byte_t tbch [2];
	byte_t cfg2 [2];
	byte_t rstat [2];
	byte_t rctrl [2];
	byte_t raddr [2];
	fs_state_e fs_state [2];

	logic acc;
	logic rd_acc;
	logic wr_pend;
	logic wr_ch;
	logic [3:0] wr_idx;
	logic a_ch;
	logic [3:0] a_idx;
	logic [1:0] clr_main;
	logic [1:0] clr_ext;

	logic [1:0] rme_ev;
	logic [1:0] rpf_ev;
	logic [1:0] pce_ev;
	logic [1:0] rfo_ev;
	logic [1:0] rfs_ev;
	logic [1:0] start_pt;
	logic [1:0] flag_two;
	logic [1:0] clean;
	logic [1:0] hard_err;
	logic [2:0] ptr;
	byte_t b_main_view;
	byte_t rd_val;
	logic irq_any;

	// bus decode; zero-wait slave, so address phase always sampled with hready
	assign acc = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	assign rd_acc = acc & ~HWRITE_IN;
	assign a_ch = HADDR_IN[`CH_SEL_BIT];
	assign a_idx = HADDR_IN[5:2];

	always_comb
	begin
		clr_main = 2'b00;
		clr_ext = 2'b00;
		if (rd_acc && a_idx == `OFF_MAIN)
		begin
			clr_main[a_ch] = 1'b1;
		end
		if (rd_acc && a_idx == `OFF_EXT)
		begin
			clr_ext[a_ch] = 1'b1;
		end
	end

	// per-channel event classification, identical for both channels
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			hard_err[c] = CRC_ERR_IN[c] | ABORT_IN[c];
			// a good frame is one no error rule diverts
			clean[c] = FRAME_END_IN[c] & ~hard_err[c] & ~FRAME_IS_S_IN[c]
				& ~(FRAME_IS_I_IN[c] & (NS_BAD_IN[c] | NR_BAD_IN[c]));
			if (tbch[c][`TBCH_DMA])
			begin
				rme_ev[c] = DMA_MSG_DONE_IN[c];
				rpf_ev[c] = 1'b0;
			end
			else
			begin
				rme_ev[c] = clean[c] | (FRAME_END_IN[c] & FRAME_IS_I_IN[c] & hard_err[c]);
				rpf_ev[c] = POOL_32_IN[c];
			end
			// s-frame crc or abort deliberately yields nothing
			pce_ev[c] = FRAME_END_IN[c] & ~hard_err[c]
				& ((FRAME_IS_I_IN[c] & NR_BAD_IN[c])
				| (FRAME_IS_S_IN[c] & (NR_BAD_IN[c] | HAS_IFIELD_IN[c])));
			rfo_ev[c] = FIFO_FULL_IN[c] & OPEN_FLAG_IN[c];
			flag_two[c] = (fs_state[c] == FS_BYTE2) & RX_BYTE_IN[c];
			start_pt[c] = cfg2[c][`CFG2_TRANSP] ? flag_two[c] : ADDR_MATCH_IN[c];
			rfs_ev[c] = start_pt[c] & cfg2[c][`CFG2_RIE];
		end
	end

	// transparent-mode frame start: count two bytes after the opening flag
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			fs_state[0] <= FS_IDLE;
			fs_state[1] <= FS_IDLE;
		end
		else if (CE_IN)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (OPEN_FLAG_IN[c])
				begin
					// a fresh flag restarts the count
					fs_state[c] <= FS_BYTE1;
				end
				else
				begin
					unique case (fs_state[c])
						FS_IDLE:
						begin
							fs_state[c] <= FS_IDLE;
						end
						FS_BYTE1:
						begin
							if (RX_BYTE_IN[c])
							begin
								fs_state[c] <= FS_BYTE2;
							end
						end
						FS_BYTE2:
						begin
							if (RX_BYTE_IN[c])
							begin
								fs_state[c] <= FS_IDLE;
							end
						end
						default:
						begin
							fs_state[c] <= FS_IDLE;
						end
					endcase
				end
			end
		end
	end

	// sticky indications: a same-cycle event beats the read clear
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			main_src[0] <= `RST_BYTE;
			main_src[1] <= `RST_BYTE;
			ext_src[0] <= `RST_BYTE;
			ext_src[1] <= `RST_BYTE;
		end
		else if (CE_IN)
		begin
			for (int c = 0; c < 2; c++)
			begin
				// events are recorded whatever the mask says
				main_src[c] <= (clr_main[c] ? `RST_BYTE : main_src[c])
					| ({7'h00, rme_ev[c]} << `MAIN_RME)
					| ({7'h00, rpf_ev[c]} << `MAIN_RPF)
					| ({7'h00, pce_ev[c]} << `MAIN_PCE);
				ext_src[c] <= (clr_ext[c] ? `RST_BYTE : ext_src[c])
					| ({7'h00, rfo_ev[c]} << `EXT_RFO)
					| ({7'h00, rfs_ev[c]} << `EXT_RFS);
			end
		end
	end

	// frame start and i-frame end snapshots, so the cpu sees stable fields after each event
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			rctrl[0] <= `RST_BYTE;
			rctrl[1] <= `RST_BYTE;
			raddr[0] <= `RST_BYTE;
			raddr[1] <= `RST_BYTE;
			rstat[0] <= `RST_BYTE;
			rstat[1] <= `RST_BYTE;
		end
		else if (CE_IN)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (start_pt[c])
				begin
					rctrl[c] <= CTRL_FIELD_IN[c];
					raddr[c] <= ADDR_FIELD_IN[c];
					rstat[c][3:0] <= RX_STAT_IN[c];
				end
				if (FRAME_END_IN[c] && FRAME_IS_I_IN[c])
				begin
					rstat[c][`RSTAT_CRC] <= CRC_ERR_IN[c];
					rstat[c][`RSTAT_ABORT] <= ABORT_IN[c];
				end
			end
		end
	end

	// protocol side effects: reply request and sequence advance
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			SFRAME_REQ_OUT <= 2'b00;
			SEQ_ADVANCE_OUT <= 2'b00;
		end
		else if (CE_IN)
		begin
			for (int c = 0; c < 2; c++)
			begin
				SFRAME_REQ_OUT[c] <= FRAME_END_IN[c] & FRAME_IS_I_IN[c] & ~hard_err[c] & NS_BAD_IN[c];
				// only a clean i-frame may move V(R); errors leave it alone
				SEQ_ADVANCE_OUT[c] <= clean[c] & FRAME_IS_I_IN[c];
			end
		end
	end

	// write data phase
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			wr_pend <= 1'b0;
			wr_ch <= 1'b0;
			wr_idx <= 4'h0;
		end
		else if (CE_IN)
		begin
			wr_pend <= acc & HWRITE_IN;
			wr_ch <= a_ch;
			wr_idx <= a_idx;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			mask[0] <= `MASK_RST;
			mask[1] <= `MASK_RST;
			tbch[0] <= `RST_BYTE;
			tbch[1] <= `RST_BYTE;
			cfg2[0] <= `RST_BYTE;
			cfg2[1] <= `RST_BYTE;
		end
		else if (CE_IN && wr_pend)
		begin
			// only the low byte lands; registers are eight bits wide
			unique case (wr_idx)
				`OFF_MASK:
				begin
					mask[wr_ch] <= HWDATA_IN[7:0];
				end
				`OFF_TBCH:
				begin
					tbch[wr_ch] <= HWDATA_IN[7:0];
				end
				`OFF_CFG2:
				begin
					cfg2[wr_ch] <= HWDATA_IN[7:0];
				end
				default:
				begin
				end
			endcase
		end
	end

	always_comb
	begin
		DMA_MODE_OUT = {tbch[1][`TBCH_DMA], tbch[0][`TBCH_DMA]};
	end

	// pointer bits: unmasked pending work in channel a main status, any pending bit in either extended register
	always_comb
	begin
		ptr[`PTR_ICA] = |(main_src[0] & ~mask[0] & `MAIN_SRC_MASK);
		ptr[`PTR_EXA] = |ext_src[0];
		ptr[`PTR_EXB] = |ext_src[1];
		b_main_view = {main_src[1][7:3], ptr};
		irq_any = |(b_main_view & ~mask[1]);
	end

	always_comb
	begin
		rd_val = `RST_BYTE;
		unique case (a_idx)
			`OFF_MAIN:
			begin
				rd_val = a_ch ? b_main_view : {main_src[0][7:3], 3'b000};
			end
			`OFF_MASK:
			begin
				rd_val = mask[a_ch];
			end
			`OFF_EXT:
			begin
				rd_val = ext_src[a_ch];
			end
			`OFF_TBCH:
			begin
				rd_val = tbch[a_ch];
			end
			`OFF_CFG2:
			begin
				rd_val = cfg2[a_ch];
			end
			`OFF_RSTAT:
			begin
				rd_val = rstat[a_ch];
			end
			`OFF_RCTRL:
			begin
				rd_val = rctrl[a_ch];
			end
			`OFF_RADDR:
			begin
				rd_val = raddr[a_ch];
			end
			default:
			begin
				rd_val = `RST_BYTE;
			end
		endcase
	end

	// read data is registered at the address phase so it stands in the data phase
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			HRDATA_OUT <= 32'h00000000;
		end
		else if (CE_IN && rd_acc)
		begin
			HRDATA_OUT <= {24'h000000, rd_val};
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end
		else
		begin
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end
	end

	// the pin follows the pending set, so it can outlive a service routine
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			IRQ_N_OUT <= 1'b1;
		end
		else if (CE_IN)
		begin
			IRQ_N_OUT <= ~irq_any;
		end
	end
endmodule

/* tb/irq_status_chk.sv */
`timescale 1ns/1ps
module irq_status_chk
(
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic HSEL_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [31:0] HRDATA_OUT,
	input wire logic [1:0] FRAME_END_IN,
	input wire logic [1:0] FRAME_IS_I_IN,
	input wire logic [1:0] FRAME_IS_S_IN,
	input wire logic [1:0] CRC_ERR_IN,
	input wire logic [1:0] ABORT_IN,
	input wire logic [1:0] NS_BAD_IN,
	input wire logic [1:0] NR_BAD_IN,
	input wire logic [1:0] SFRAME_REQ_OUT,
	input wire logic [1:0] SEQ_ADVANCE_OUT,
	input wire logic [1:0] DMA_MODE_OUT,
	input wire logic IRQ_N_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	wire logic acc = HSEL_IN && HTRANS_IN[1];
	wire logic [1:0] bad = CRC_ERR_IN | ABORT_IN;
	wire logic [1:0] nsr = FRAME_END_IN & FRAME_IS_I_IN & NS_BAD_IN & ~bad;
	wire logic [1:0] cln = FRAME_END_IN & FRAME_IS_I_IN & ~bad & ~NS_BAD_IN & ~NR_BAD_IN;
	a_reply_on_ns: assert property (nsr[0] |=> SFRAME_REQ_OUT[0]) else $error("no s reply");
	a_reply_cause: assert property (SFRAME_REQ_OUT[1] |-> $past(nsr[1])) else $error("stray s reply");
	a_sframe_silent: assert property (FRAME_END_IN[0] && FRAME_IS_S_IN[0] |=> !SFRAME_REQ_OUT[0])
		else $error("reply to s frame");
	a_seq_clean: assert property (SEQ_ADVANCE_OUT[0] |-> $past(cln[0])) else $error("bad advance");
	a_seq_err: assert property (FRAME_END_IN[1] && bad[1] |=> !SEQ_ADVANCE_OUT[1]) else $error("error advance");
	a_byte_data: assert property (HRDATA_OUT[31:8] == 24'h0) else $error("wide read data");
	a_dma_write: assert property (!$stable(DMA_MODE_OUT) |-> $past(acc && HWRITE_IN, 2))
		else $error("dma mode moved");
	// a clearing read shows two edges later, a mask write one edge more
	a_irq_release: assert property ($rose(IRQ_N_OUT) |-> $past(acc, 2) || $past(acc && HWRITE_IN, 3))
		else $error("irq dropped alone");
	c_reply: cover property (SFRAME_REQ_OUT[0]);
	c_irq: cover property ($fell(IRQ_N_OUT));
	c_dma: cover property (DMA_MODE_OUT[0]);
endmodule

bind hdlc_irq_status irq_status_chk u_chk (.CLK_IN, .SYS_RST_IN, .HSEL_IN, .HTRANS_IN, .HWRITE_IN, .HRDATA_OUT,
	.FRAME_END_IN, .FRAME_IS_I_IN, .FRAME_IS_S_IN, .CRC_ERR_IN, .ABORT_IN, .NS_BAD_IN, .NR_BAD_IN,
	.SFRAME_REQ_OUT, .SEQ_ADVANCE_OUT, .DMA_MODE_OUT, .IRQ_N_OUT);

/* tb/host_cpu.sv */
`timescale 1ns/1ps
module host_cpu
(
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel = 1'h0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'h0,
	output logic [31:0] hwdata = 32'h0
);
	// single word transfers only; the caller decides the service order
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		// unused data lines toggle so a stale value cannot look valid
		hwdata <= w ? d : ~hwdata;
		do @(posedge clk); while (hready !== 1'h1);
		r = hrdata;
	endtask
endmodule

/* tb/hdlc_irq_status_tb.sv */
`timescale 1ns/1ps
module hdlc_irq_status_tb;
	import irq_status_pkg::*;
	logic CLK_IN = 1'h0;
	logic SYS_RST_IN = 1'h1;
	logic ce = 1'h1;
	logic [1:0] fe = 0, fi = 0, fs = 0, fc = 0, fa = 0, fn = 0, fr = 0, fd = 0;
	logic [1:0] p32 = 0, dmd = 0, ful = 0, opf = 0, adm = 0, rxb = 0, dmm = 0;
	byte_t ctl [2] = '{8'h0, 8'h0};
	byte_t adr [2] = '{8'h0, 8'h0};
	logic [3:0] rs4 [2] = '{4'h0, 4'h0};
	wire logic hsel, hwrite, hready, hresp, irq_n;
	wire logic [1:0] htrans, sreq, sadv, dmo;
	wire logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] mm [2] = '{8'h0, 8'h0};
	logic [7:0] em [2] = '{8'h0, 8'h0};
	logic [7:0] km [2] = '{8'h0, 8'h0};
	logic [6:0] kin [9] = '{7'h50, 7'h48, 7'h44, 7'h42, 7'h30, 7'h28, 7'h22, 7'h21, 7'h40};
	logic [31:0] v;
	int miscompares = 0, checks_done = 0, cyc = 0;
	int unsigned rng = 78428;

	host_cpu host (.clk(CLK_IN), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata));
	hdlc_irq_status uut (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CE_IN(ce), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .FRAME_END_IN(fe), .FRAME_IS_I_IN(fi),
		.FRAME_IS_S_IN(fs), .CRC_ERR_IN(fc), .ABORT_IN(fa), .NS_BAD_IN(fn), .NR_BAD_IN(fr), .HAS_IFIELD_IN(fd),
		.POOL_32_IN(p32), .DMA_MSG_DONE_IN(dmd), .FIFO_FULL_IN(ful), .OPEN_FLAG_IN(opf), .ADDR_MATCH_IN(adm),
		.RX_BYTE_IN(rxb), .CTRL_FIELD_IN(ctl), .ADDR_FIELD_IN(adr), .RX_STAT_IN(rs4), .SFRAME_REQ_OUT(sreq),
		.SEQ_ADVANCE_OUT(sadv), .DMA_MODE_OUT(dmo), .IRQ_N_OUT(irq_n));

	initial
	begin
		forever #12.5 CLK_IN = ~CLK_IN;
	end

	function int unsigned xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	function logic [7:0] view();
		return mm[1] | {5'h0, (mm[0] & ~km[0] & 8'hf8) != 0, em[0] != 0, em[1] != 0};
	endfunction

	task finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	task rd(input int c, input logic [7:0] o);
		host.xfer(1'h0, {25'h0, c[0], o[5:0]}, 32'h0, v);
	endtask

	task wr(input int c, input logic [7:0] o, input logic [7:0] d);
		host.xfer(1'h1, {25'h0, c[0], o[5:0]}, {24'h0, d}, v);
	endtask

	task rmain(input int c);
		rd(c, 8'h0);
		chk(v[7:0], c ? view() : mm[0]);
		mm[c] = 8'h0;
	endtask

	task rext(input int c);
		rd(c, 8'h8);
		chk(v[7:0], em[c]);
		em[c] = 8'h0;
	endtask

	task irq_chk();
		repeat (2) @(posedge CLK_IN);
		#1;
		chk(irq_n, (view() & ~km[1]) == 0);
	endtask

	task pu(input int w, input int c);
		@(posedge CLK_IN);
		case (w)
			0: p32[c] <= 1'h1;
			1: dmd[c] <= 1'h1;
			2: opf[c] <= 1'h1;
			3: adm[c] <= 1'h1;
			default: rxb[c] <= 1'h1;
		endcase
		@(posedge CLK_IN);
		{p32, dmd, opf, adm, rxb} <= 10'h0;
	endtask

	task frame(input int c, input logic [6:0] k);
		logic bad;
		bad = k[4] | k[3];
		@(posedge CLK_IN);
		fe[c] <= 1'h1;
		{fi[c], fs[c], fc[c], fa[c], fn[c], fr[c], fd[c]} <= k;
		@(posedge CLK_IN);
		{fe, fi, fs, fc, fa, fn, fr, fd} <= 16'h0;
		#1;
		chk(sreq[c], k[6] & !bad & k[2]);
		chk(sadv[c], k[6] & !bad & !k[2] & !k[1]);
		// an i-frame with a bad sequence number gives no message end unless it also has a crc error or abort
		mm[c] |= {k[6] & !dmm[c] & (bad | !(k[2] | k[1])), 1'h0, !bad & (k[1] | k[5] & k[0]), 5'h0};
	endtask

	always @(posedge CLK_IN)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end

	initial
	begin
		repeat (4) @(posedge CLK_IN);
		SYS_RST_IN <= 1'h0;
		for (int i = 0; i < 17; i++)
		begin
			rd(i / 8, (i % 8) * 4);
			chk(v, 8'h0);
		end
		chk(hresp, 1'h0);
		$display("reset test done");
		for (int k = 0; k < 9; k++)
		begin
			int c;
			c = xs() & 1;
			frame(c, kin[k]);
			irq_chk();
			if (kin[k][6] & (kin[k][4] | kin[k][3]))
			begin
				rd(c, 8'h14);
				chk(v[5:4], kin[k][4:3]);
			end
			rmain(1);
			rmain(0);
			irq_chk();
		end
		$display("error table test done");
		wr(0, 8'h4, 8'h80);
		km[0] = 8'h80;
		frame(0, kin[0]);
		irq_chk();
		rd(0, 8'h4);
		chk(v, km[0]);
		wr(0, 8'h4, 8'h0);
		km[0] = 8'h0;
		irq_chk();
		wr(1, 8'h4, 8'hff);
		km[1] = 8'hff;
		irq_chk();
		wr(1, 8'h4, 8'h0);
		km[1] = 8'h0;
		irq_chk();
		rmain(1);
		rmain(0);
		irq_chk();
		$display("mask test done");
		wr(0, 8'hc, 8'h80);
		dmm[0] = 1'h1;
		#1;
		chk(dmo, dmm);
		pu(0, 0);
		pu(0, 1);
		mm[1][6] = 1'h1;
		frame(0, kin[8]);
		pu(1, 0);
		mm[0][7] = 1'h1;
		irq_chk();
		rmain(1);
		rmain(0);
		wr(0, 8'hc, 8'h0);
		dmm[0] = 1'h0;
		$display("dma test done");
		// with the enable low a pool-full pulse must leave no trace
		ce <= 1'h0;
		pu(0, 1);
		ce <= 1'h1;
		rmain(1);
		$display("clock enable test done");
		ful <= 2'h1;
		pu(2, 0);
		pu(2, 1);
		em[0][6] = 1'h1;
		ful <= 2'h0;
		irq_chk();
		rmain(1);
		rext(0);
		rext(1);
		ctl[1] <= xs();
		adr[1] <= xs();
		rs4[1] <= xs();
		pu(3, 1);
		rext(1);
		wr(1, 8'h10, 8'h08);
		pu(3, 1);
		em[1][3] = 1'h1;
		rext(1);
		rd(1, 8'h18);
		chk(v, ctl[1]);
		rd(1, 8'h1c);
		chk(v, adr[1]);
		rd(1, 8'h14);
		chk(v[3:0], rs4[1]);
		wr(1, 8'h10, 8'h09);
		pu(2, 1);
		pu(4, 1);
		rext(1);
		pu(4, 1);
		em[1][3] = 1'h1;
		rext(1);
		$display("frame start test done");
		finish_test();
	end
endmodule
